// ### rtl/pll_status_and_synth_config.sv
// Purpose: status and synthesizer configuration register bank, one channel
// Assumes: byte register port synchronous to clk_i, 40 MHz
// Notes:   reads return data one cycle after rd_en_i
//
// Operation
// - tuning offset bits 31:24 readable at 0x68, read-only, reset zero.
// - 32-bit phase word over 0x7d..0x80, low byte at lowest address.
// - phase word follows present phase detector output.
// - one phase LSB is two to minus ten nanoseconds.
// - positive when input leads feedback, negative when it lags.
// - second divider enabled only if global enable, its enable, no bypass.
// - bypass set routes bypass mux to second path, else second divider.
// - second ratio bits 7:4, 4 to 7.5 by halves then 8 to 15.
// - first ratio bits 3:0, same mapping as second.
// - code 000 crystal; 001-011 input clocks to synth and bypass mux.
// - codes 110/111 loop to synth; 110 crystal to bypass, 111 none.
// - codes 100/101 loop to synth; 100 input one to bypass, 101 none.
// - loop may power down when mux code top bit is zero.
// - decrement source bits 6:4: register bit, pins zero to three, unused.
// - decrement phase on every edge of decrement source.
// - increment phase on every edge of increment source.
// - decrement moves output edge earlier.
// - increment moves output edge later.
// - register increment bit 3 is source when bits 2:0 are 000.
`include "synth_cfg_defs.svh"
module pll_status_and_synth_config import synth_cfg_pkg::*; (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [8:0]  addr_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [7:0]  wr_data_i,
    output logic      [7:0]  rd_data_o,
    input  wire logic [31:0] tuning_offset_status_i,
    input  wire logic [31:0] phase_detect_i,
    input  wire logic        synth_global_enable_i,
    input  wire logic [3:0]  gpio_i,
    output logic             second_divider_on_o,
    output logic             second_path_bypass_o,
    output logic [4:0]       first_half_ratio_o,
    output logic [4:0]       second_half_ratio_o,
    output synth_source_t    synth_source_o,
    output bypass_source_t   bypass_source_o,
    output logic             loop_power_down_ok_o,
    output logic             phase_earlier_o,
    output logic             phase_later_o
);
    // ---------------------------------------------------------------
    // configuration registers
    // ---------------------------------------------------------------
    logic [7:0]  enable_bypass_q;
    logic [7:0]  divider_select_q;
    logic [2:0]  input_select_q;
    logic [7:0]  phase_step_select_q;
    logic [31:0] phase_status_q;
    logic [7:0]  tuning_offset_q;
    logic        down_step;
    logic        up_step;
    logic [4:0]  first_half;
    logic [4:0]  second_half;
    logic        bypass_sel;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_bypass_q     <= `REG_RESET_VALUE;
            divider_select_q    <= `REG_RESET_VALUE;
            input_select_q      <= 3'h0;
            phase_step_select_q <= `REG_RESET_VALUE;
        end else if (wr_en_i) begin
            unique case (addr_i)
                `SYNTH_ENABLE_BYPASS_ADDR:
                    enable_bypass_q <= {5'h00, wr_data_i[2:1], 1'b0};
                `SYNTH_DIVIDER_SELECT_ADDR:    divider_select_q    <= wr_data_i;
                `SYNTH_INPUT_MUX_ADDR:
                    input_select_q <= wr_data_i[`INPUT_SELECT_MSB:`INPUT_SELECT_LSB];
                `SYNTH_PHASE_STEP_SELECT_ADDR: phase_step_select_q <= wr_data_i;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // status capture
    // ---------------------------------------------------------------
    // detector sign convention (input leads = positive, 2^-10 ns LSB) kept as is
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_status_q  <= 32'h0000_0000;
            tuning_offset_q <= `REG_RESET_VALUE;
        end else begin
            phase_status_q  <= phase_detect_i;
            tuning_offset_q <= tuning_offset_status_i[31:24];
        end
    end

    // ---------------------------------------------------------------
    // read port
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_en_i) begin
            unique case (addr_i)
                `TUNING_OFFSET_BYTE3_ADDR:     rd_data_o <= tuning_offset_q;
                `PHASE_STATUS_BYTE0_ADDR:      rd_data_o <= phase_status_q[7:0];
                `PHASE_STATUS_BYTE1_ADDR:      rd_data_o <= phase_status_q[15:8];
                `PHASE_STATUS_BYTE2_ADDR:      rd_data_o <= phase_status_q[23:16];
                `PHASE_STATUS_BYTE3_ADDR:      rd_data_o <= phase_status_q[31:24];
                `SYNTH_ENABLE_BYPASS_ADDR:     rd_data_o <= enable_bypass_q;
                `SYNTH_DIVIDER_SELECT_ADDR:    rd_data_o <= divider_select_q;
                `SYNTH_INPUT_MUX_ADDR:         rd_data_o <= {5'h00, input_select_q};
                `SYNTH_PHASE_STEP_SELECT_ADDR: rd_data_o <= phase_step_select_q;
                default:                       rd_data_o <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // divider control
    // ---------------------------------------------------------------
    assign bypass_sel = enable_bypass_q[`SECOND_PATH_BYPASS_BIT];
    assign second_divider_on_o = synth_global_enable_i
        & enable_bypass_q[`SECOND_DIVIDER_ENABLE_BIT] & ~bypass_sel;
    assign second_path_bypass_o = bypass_sel;

    ratio_decode u_first_ratio (
        .code_i       (divider_select_q[`FIRST_RATIO_MSB:`FIRST_RATIO_LSB]),
        .half_ratio_o (first_half)
    );
    ratio_decode u_second_ratio (
        .code_i       (divider_select_q[`SECOND_RATIO_MSB:`SECOND_RATIO_LSB]),
        .half_ratio_o (second_half)
    );
    assign first_half_ratio_o  = first_half;
    assign second_half_ratio_o = second_half;

    // ---------------------------------------------------------------
    // input mux decode
    // ---------------------------------------------------------------
    // 111/101 leave the bypass mux idle; software must keep bypass at 0
    always_comb begin
        unique case (input_select_t'(input_select_q))
            MUX_CRYSTAL: begin
                synth_source_o  = SRC_CRYSTAL;
                bypass_source_o = BYP_NONE;
            end
            MUX_INPUT_ONE: begin
                synth_source_o  = SRC_CLOCK_ONE;
                bypass_source_o = BYP_CLOCK_ONE;
            end
            MUX_INPUT_TWO: begin
                synth_source_o  = SRC_CLOCK_TWO;
                bypass_source_o = BYP_CLOCK_TWO;
            end
            MUX_INPUT_THREE: begin
                synth_source_o  = SRC_CLOCK_THREE;
                bypass_source_o = BYP_CLOCK_THREE;
            end
            MUX_LOOP_IN1_BYP: begin
                synth_source_o  = SRC_LOOP;
                bypass_source_o = BYP_CLOCK_ONE;
            end
            MUX_LOOP_IN1_NONE: begin
                synth_source_o  = SRC_LOOP;
                bypass_source_o = BYP_NONE;
            end
            MUX_LOOP_XTAL_BYP: begin
                synth_source_o  = SRC_LOOP;
                bypass_source_o = BYP_CRYSTAL;
            end
            MUX_LOOP_NONE: begin
                synth_source_o  = SRC_LOOP;
                bypass_source_o = BYP_NONE;
            end
        endcase
    end

    assign loop_power_down_ok_o = ~input_select_q[2];

    // ---------------------------------------------------------------
    // phase stepping
    // ---------------------------------------------------------------
    step_edge_detect u_down_step (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .src_sel_i (phase_step_select_q[`PHASE_DOWN_SRC_MSB:`PHASE_DOWN_SRC_LSB]),
        .reg_bit_i (phase_step_select_q[`PHASE_DOWN_BIT_POS]),
        .gpio_i    (gpio_i),
        .step_o    (down_step)
    );
    step_edge_detect u_up_step (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .src_sel_i (phase_step_select_q[`PHASE_UP_SRC_MSB:`PHASE_UP_SRC_LSB]),
        .reg_bit_i (phase_step_select_q[`PHASE_UP_BIT_POS]),
        .gpio_i    (gpio_i),
        .step_o    (up_step)
    );

    // pulses registered; one cycle per source transition
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_earlier_o <= 1'b0;
            phase_later_o   <= 1'b0;
        end else begin
            phase_earlier_o <= down_step;
            phase_later_o   <= up_step;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_tuning_byte_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_en_i && addr_i == `TUNING_OFFSET_BYTE3_ADDR
        |=> rd_data_o == $past(tuning_offset_status_i[31:24], 2))
        else $error("tuning byte read wrong");

    a_phase_low_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_en_i && addr_i == `PHASE_STATUS_BYTE0_ADDR
        |=> rd_data_o == $past(phase_detect_i[7:0], 2))
        else $error("phase low byte wrong");

    a_phase_byte_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_en_i && addr_i == `PHASE_STATUS_BYTE1_ADDR
        |=> rd_data_o == $past(phase_detect_i[15:8], 2))
        else $error("phase byte one wrong");

    a_phase_byte_two: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_en_i && addr_i == `PHASE_STATUS_BYTE2_ADDR
        |=> rd_data_o == $past(phase_detect_i[23:16], 2))
        else $error("phase byte two wrong");

    a_read_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !rd_en_i
        |=> $stable(rd_data_o))
        else $error("read data changed without read");

    a_phase_top_byte: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        rd_en_i && addr_i == `PHASE_STATUS_BYTE3_ADDR
        |=> rd_data_o == $past(phase_detect_i[31:24], 2))
        else $error("phase top byte wrong");

    a_phase_sign_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        ##1 phase_status_q[31] == $past(phase_detect_i[31]))
        else $error("phase sign changed");

    a_divider_enable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        second_divider_on_o |-> synth_global_enable_i && !second_path_bypass_o)
        else $error("second divider enabled illegally");

    a_divider_all_set: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        synth_global_enable_i && enable_bypass_q[`SECOND_DIVIDER_ENABLE_BIT] && !bypass_sel
        |-> second_divider_on_o)
        else $error("second divider not enabled");

    a_bypass_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `SYNTH_ENABLE_BYPASS_ADDR
        |=> second_path_bypass_o == $past(wr_data_i[1]))
        else $error("bypass not written");

    a_ratio_top_codes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        divider_select_q[7] |-> second_half_ratio_o == {divider_select_q[7:4], 1'b0})
        else $error("second ratio decode wrong");

    a_ratio_mid_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        divider_select_q[7:4] == 4'h7
        |-> second_half_ratio_o == 5'h0f)
        else $error("second ratio half step wrong");

    a_divider_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `SYNTH_DIVIDER_SELECT_ADDR
        |=> divider_select_q == $past(wr_data_i))
        else $error("divider select not written");

    a_ratio_low_codes: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        divider_select_q[3:0] == 4'h1 |-> first_half_ratio_o == 5'h09)
        else $error("first ratio decode wrong");

    a_first_top_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        divider_select_q[3:0] == 4'hf
        |-> first_half_ratio_o == 5'h1e)
        else $error("first ratio top code wrong");

    a_crystal_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        input_select_q == 3'b000 |-> synth_source_o == SRC_CRYSTAL)
        else $error("crystal source decode wrong");

    a_input_one_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        input_select_q == 3'b001
        |-> synth_source_o == SRC_CLOCK_ONE && bypass_source_o == BYP_CLOCK_ONE)
        else $error("input one decode wrong");

    a_mux_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `SYNTH_INPUT_MUX_ADDR
        |=> input_select_q == $past(wr_data_i[2:0]))
        else $error("input mux not written");

    a_loop_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        input_select_q[2] |-> synth_source_o == SRC_LOOP && !loop_power_down_ok_o)
        else $error("loop source decode wrong");

    a_crystal_bypass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        input_select_q == 3'b110
        |-> bypass_source_o == BYP_CRYSTAL)
        else $error("crystal bypass decode wrong");

    a_loop_no_bypass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        input_select_q == 3'b111
        |-> bypass_source_o == BYP_NONE)
        else $error("idle bypass decode wrong");

    a_master_one_bypass: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        input_select_q == 3'b100
        |-> bypass_source_o == BYP_CLOCK_ONE)
        else $error("input one bypass decode wrong");

    a_power_down_ok: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !input_select_q[2]
        |-> loop_power_down_ok_o)
        else $error("power down flag wrong");

    a_step_select_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_en_i && addr_i == `SYNTH_PHASE_STEP_SELECT_ADDR
        |=> phase_step_select_q == $past(wr_data_i))
        else $error("step select not written");

    a_unused_no_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (phase_step_select_q[6:4] == 3'b111) [*5]
        |-> !phase_earlier_o)
        else $error("unused source stepped");

    a_down_bit_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        phase_step_select_q[6:4] == 3'b000 && $past(phase_step_select_q[6:4]) == 3'b000
        && $changed(phase_step_select_q[7])
        ##1 (phase_step_select_q[6:4] == 3'b000) [*2] |=> phase_earlier_o)
        else $error("decrement step missing");

    a_up_bit_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        phase_step_select_q[2:0] == 3'b000 && $past(phase_step_select_q[2:0]) == 3'b000
        && $changed(phase_step_select_q[3])
        ##1 (phase_step_select_q[2:0] == 3'b000) [*2] |=> phase_later_o)
        else $error("increment step missing");

    a_down_single: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        phase_earlier_o |=> !phase_earlier_o)
        else $error("decrement step repeated");
endmodule

// ### rtl/ratio_decode.sv
// Purpose: decode a 4-bit divider ratio code into half-units
// Assumes: result is ratio times two
// Notes:   codes 0-7 give 4..7.5 by halves, 8-15 give 8..15
module ratio_decode (
    input  wire logic [3:0] code_i,
    output logic      [4:0] half_ratio_o
);
    always_comb begin
        if (code_i[3]) begin
            half_ratio_o = {code_i, 1'b0};
        end else begin
            half_ratio_o = 5'h08 + {2'h0, code_i[2:0]};
        end
    end
endmodule

// ### rtl/step_edge_detect.sv
// Purpose: pick a phase-step source, synchronise it, flag both edges
// Assumes: pins asynchronous to clk_i
// Notes:   codes 101-111 select a constant low, so never step
module step_edge_detect (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [2:0] src_sel_i,
    input  wire logic       reg_bit_i,
    input  wire logic [3:0] gpio_i,
    output logic            step_o
);
    logic       raw;
    logic [2:0] sync_q;

    always_comb begin
        unique case (src_sel_i)
            3'b000:  raw = reg_bit_i;
            3'b001:  raw = gpio_i[0];
            3'b010:  raw = gpio_i[1];
            3'b011:  raw = gpio_i[2];
            3'b100:  raw = gpio_i[3];
            default: raw = 1'b0;
        endcase
    end

    // sync_q[0] feeds only sync_q[1]
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], raw};
        end
    end

    assign step_o = sync_q[2] ^ sync_q[1];
endmodule

// ### rtl/synth_cfg_defs.svh
// Purpose: offsets, field positions and reset values of the synth config bank
// Assumes: byte-wide register port, 9-bit byte address
// Notes:   definitions only
`ifndef SYNTH_CFG_DEFS_SVH
`define SYNTH_CFG_DEFS_SVH

`define TUNING_OFFSET_BYTE3_ADDR     9'h068
`define PHASE_STATUS_BYTE0_ADDR      9'h07d
`define PHASE_STATUS_BYTE1_ADDR      9'h07e
`define PHASE_STATUS_BYTE2_ADDR      9'h07f
`define PHASE_STATUS_BYTE3_ADDR      9'h080
`define SYNTH_ENABLE_BYPASS_ADDR     9'h100
`define SYNTH_DIVIDER_SELECT_ADDR    9'h101
`define SYNTH_INPUT_MUX_ADDR         9'h102
`define SYNTH_PHASE_STEP_SELECT_ADDR 9'h103

`define REG_RESET_VALUE              8'h00

`define SECOND_DIVIDER_ENABLE_BIT    2
`define SECOND_PATH_BYPASS_BIT       1
`define SECOND_RATIO_MSB             7
`define SECOND_RATIO_LSB             4
`define FIRST_RATIO_MSB              3
`define FIRST_RATIO_LSB              0
`define INPUT_SELECT_MSB             2
`define INPUT_SELECT_LSB             0
`define PHASE_DOWN_BIT_POS           7
`define PHASE_DOWN_SRC_MSB           6
`define PHASE_DOWN_SRC_LSB           4
`define PHASE_UP_BIT_POS             3
`define PHASE_UP_SRC_MSB             2
`define PHASE_UP_SRC_LSB             0

`endif

// ### rtl/synth_cfg_pkg.sv
// Purpose: types shared by the synth config bank
// Assumes: nothing
// Notes:   codes are the documented field encodings
package synth_cfg_pkg;

    typedef enum logic [2:0] {
        MUX_CRYSTAL    = 3'b000,
        MUX_INPUT_ONE  = 3'b001,
        MUX_INPUT_TWO  = 3'b010,
        MUX_INPUT_THREE = 3'b011,
        MUX_LOOP_IN1_BYP = 3'b100,
        MUX_LOOP_IN1_NONE = 3'b101,
        MUX_LOOP_XTAL_BYP = 3'b110,
        MUX_LOOP_NONE  = 3'b111
    } input_select_t;

    // synth input source
    typedef enum logic [2:0] {
        SRC_CRYSTAL   = 3'b000,
        SRC_CLOCK_ONE = 3'b001,
        SRC_CLOCK_TWO = 3'b010,
        SRC_CLOCK_THREE = 3'b011,
        SRC_LOOP      = 3'b100
    } synth_source_t;

    // bypass-mux source
    typedef enum logic [2:0] {
        BYP_NONE      = 3'b000,
        BYP_CRYSTAL   = 3'b001,
        BYP_CLOCK_ONE = 3'b010,
        BYP_CLOCK_TWO = 3'b011,
        BYP_CLOCK_THREE = 3'b100
    } bypass_source_t;

endpackage

// ### verif/tb_top.sv
// Purpose: self-checking bench for the synth config and status register bank
// Assumes: byte port sampled on rising clk_i, inputs driven on falling edge
// Notes:   step pulses counted over a fixed eight-cycle window
`include "synth_cfg_defs.svh"
module tb_top import synth_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic           clk_i = 1'b0;
    logic           rst_n_i = 1'b0;
    logic [8:0]     addr_i = 9'h000;
    logic           wr_en_i = 1'b0;
    logic           rd_en_i = 1'b0;
    logic [7:0]     wr_data_i = 8'h00;
    logic [7:0]     rd_data_o;
    logic [31:0]    tuning_offset_status_i = 32'h0;
    logic [31:0]    phase_detect_i = 32'h0;
    logic           synth_global_enable_i = 1'b0;
    logic [3:0]     gpio_i = 4'h0;
    logic           second_divider_on_o;
    logic           second_path_bypass_o;
    logic [4:0]     first_half_ratio_o;
    logic [4:0]     second_half_ratio_o;
    synth_source_t  synth_source_o;
    bypass_source_t bypass_source_o;
    logic           loop_power_down_ok_o;
    logic           phase_earlier_o;
    logic           phase_later_o;
    int             bad_count = 0;
    int             check_count = 0;
    int             up_cnt = 0;
    int             dn_cnt = 0;

    typedef struct {
        logic [2:0] code;
        logic [2:0] src;
        logic [2:0] byp;
    } mux_row_t;

    mux_row_t rows [8] = '{
        '{3'h0, SRC_CRYSTAL, BYP_NONE}, '{3'h1, SRC_CLOCK_ONE, BYP_CLOCK_ONE},
        '{3'h2, SRC_CLOCK_TWO, BYP_CLOCK_TWO}, '{3'h3, SRC_CLOCK_THREE, BYP_CLOCK_THREE},
        '{3'h4, SRC_LOOP, BYP_CLOCK_ONE}, '{3'h5, SRC_LOOP, BYP_NONE},
        '{3'h6, SRC_LOOP, BYP_CRYSTAL}, '{3'h7, SRC_LOOP, BYP_NONE}};

    pll_status_and_synth_config i_pll_status_and_synth_config (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
        .tuning_offset_status_i(tuning_offset_status_i), .phase_detect_i(phase_detect_i),
        .synth_global_enable_i(synth_global_enable_i), .gpio_i(gpio_i),
        .second_divider_on_o(second_divider_on_o),
        .second_path_bypass_o(second_path_bypass_o),
        .first_half_ratio_o(first_half_ratio_o), .second_half_ratio_o(second_half_ratio_o),
        .synth_source_o(synth_source_o), .bypass_source_o(bypass_source_o),
        .loop_power_down_ok_o(loop_power_down_ok_o), .phase_earlier_o(phase_earlier_o),
        .phase_later_o(phase_later_o));

    always #12.5 clk_i = ~clk_i;

    // a pulse is one cycle wide, so each high sample is one step
    always @(posedge clk_i) begin
        if (phase_later_o === 1'b1) up_cnt++;
        if (phase_earlier_o === 1'b1) dn_cnt++;
    end

    // ----------------------------------------
    // compare and bus tasks
    // ----------------------------------------
    task automatic chk_val(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_cnt(string what, int exp, int got);
        check_count++;
        if (got != exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(logic [8:0] a, logic [7:0] d);
        addr_i = a;
        wr_data_i = d;
        wr_en_i = 1'b1;
        @(negedge clk_i);
        wr_en_i = 1'b0;
    endtask

    task automatic rd(logic [8:0] a, logic [7:0] exp);
        addr_i = a;
        rd_en_i = 1'b1;
        @(negedge clk_i);
        rd_en_i = 1'b0;
        @(negedge clk_i);
        chk_val("read data", {24'h0, exp}, {24'h0, rd_data_o});
    endtask

    task automatic steps(int up_exp, int dn_exp);
        repeat (8) @(negedge clk_i);
        chk_cnt("up steps", up_exp, up_cnt);
        chk_cnt("down steps", dn_exp, dn_cnt);
        up_cnt = 0;
        dn_cnt = 0;
    endtask

    // divide ratio times two, by code
    logic [4:0] ratio_x2 [16] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
        5'h10, 5'h12, 5'h14, 5'h16, 5'h18, 5'h1a, 5'h1c, 5'h1e};

    function automatic logic [4:0] half(logic [3:0] c);
        return ratio_x2[c];
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // watchdog, far beyond the ~400-cycle run
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        conclude();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [8:0] ad [9] = '{`TUNING_OFFSET_BYTE3_ADDR, `PHASE_STATUS_BYTE0_ADDR,
            `PHASE_STATUS_BYTE1_ADDR, `PHASE_STATUS_BYTE2_ADDR, `PHASE_STATUS_BYTE3_ADDR,
            `SYNTH_ENABLE_BYPASS_ADDR, `SYNTH_DIVIDER_SELECT_ADDR, `SYNTH_INPUT_MUX_ADDR,
            `SYNTH_PHASE_STEP_SELECT_ADDR};
        logic [7:0] b;
        repeat (16) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        foreach (ad[i]) rd(ad[i], 8'h00);
        chk_val("first ratio", 32'd8, first_half_ratio_o);
        chk_val("power down ok", 32'd1, loop_power_down_ok_o);
        // mux decode table
        foreach (rows[i]) begin
            wr(`SYNTH_INPUT_MUX_ADDR, {5'h1f, rows[i].code});
            chk_val("synth source", rows[i].src, synth_source_o);
            chk_val("bypass source", rows[i].byp, bypass_source_o);
            chk_val("power down ok", {31'h0, ~rows[i].code[2]}, loop_power_down_ok_o);
            rd(`SYNTH_INPUT_MUX_ADDR, {5'h0, rows[i].code});
        end
        wr(`SYNTH_INPUT_MUX_ADDR, 8'h06);
        chk_val("normal source", SRC_LOOP, synth_source_o);
        rd(`SYNTH_INPUT_MUX_ADDR, 8'h06);
        for (int c = 0; c < 16; c++) begin
            b = {c[3:0], 4'hf - c[3:0]};
            wr(`SYNTH_DIVIDER_SELECT_ADDR, b);
            chk_val("second ratio", half(b[7:4]), second_half_ratio_o);
            chk_val("first ratio", half(b[3:0]), first_half_ratio_o);
            rd(`SYNTH_DIVIDER_SELECT_ADDR, b);
        end
        for (int i = 0; i < 8; i++) begin
            synth_global_enable_i = i[2];
            wr(`SYNTH_ENABLE_BYPASS_ADDR, {5'h1f, i[1], i[0], 1'b1});
            chk_val("divider on", i[2] & i[1] & ~i[0], second_divider_on_o);
            chk_val("bypass", i[0], second_path_bypass_o);
            rd(`SYNTH_ENABLE_BYPASS_ADDR, {5'h0, i[1], i[0], 1'b0});
        end
        // status bytes, a lagging then a leading phase
        tuning_offset_status_i = 32'h8123_4567;
        phase_detect_i = 32'hfedc_ba98;
        repeat (3) @(negedge clk_i);
        wr(`TUNING_OFFSET_BYTE3_ADDR, 8'hff);
        rd(`TUNING_OFFSET_BYTE3_ADDR, 8'h81);
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < 4; j++)
                rd(`PHASE_STATUS_BYTE0_ADDR + 9'(j), phase_detect_i[8*j +: 8]);
            phase_detect_i = 32'h0000_0401;
            repeat (3) @(negedge clk_i);
        end
        rd(`PHASE_STATUS_BYTE1_ADDR, 8'h04);
        wr(9'h104, 8'h5a);
        rd(9'h104, 8'h00);
        // phase steps from the register bits
        steps(0, 0);
        wr(`SYNTH_PHASE_STEP_SELECT_ADDR, 8'h08);
        steps(1, 0);
        wr(`SYNTH_PHASE_STEP_SELECT_ADDR, 8'h00);
        steps(1, 0);
        wr(`SYNTH_PHASE_STEP_SELECT_ADDR, 8'h80);
        steps(0, 1);
        wr(`SYNTH_PHASE_STEP_SELECT_ADDR, 8'h00);
        steps(0, 1);
        // pins: unselected pins must not step
        for (int s = 1; s < 8; s++) begin
            wr(`SYNTH_PHASE_STEP_SELECT_ADDR, {1'b0, s[2:0], 1'b0, s[2:0]});
            gpio_i = (s < 5) ? 4'hf ^ (4'h1 << (s - 1)) : 4'hf;
            steps(0, 0);
            gpio_i = 4'hf;
            steps(s < 5, s < 5);
            gpio_i = 4'h0;
            steps(s < 5, s < 5);
        end
        // second reset in mid-run clears the bank
        wr(`SYNTH_DIVIDER_SELECT_ADDR, 8'h3c);
        rst_n_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        for (int i = 5; i < 9; i++) rd(ad[i], 8'h00);
        chk_val("second ratio", 32'd8, second_half_ratio_o);
        conclude();
    end
endmodule
